// ### hw/cffb_map.svh
// Constants for the CAN frame filter and byte select block.
// Assumes a 100 MHz ref_clk and a 32-bit plain register port.
//
// Notes on behaviour
// - The filter takes an identifier type of standard (0 to 7ff) or extended (0 to 1fffffff).
// - The programmed identifier is a hardware filter; only frames carrying it reach the outgoing records.
// - Each frame has eight data bytes; only bytes whose mask bit is set go upstream.
// - In automatic rate mode the block keeps hunting for a bus, even with none attached.
// - For the standard vehicle-parameter messages the identifier type is extended 29-bit.
// - The identifier is four bytes; in extended mode, outer bytes written as ff match any value.
// - A frame that passes filter and byte selection is appended to the outgoing records.
// - Selected bytes form a value whose least significant byte is the first one received.
// - A scan request collects the messages present on the bus once and reports them.
// - With monitoring on, the scan repeats every 3 s until monitoring is turned off.
// - The CAN function runs only with no USB cable attached and outside deep sleep.
// - Fixed rates 50, 100, 125, 250 and 500 kbit/s are offered besides automatic mode.
`ifndef CFFB_MAP_SVH
`define CFFB_MAP_SVH

// ==========================================
// Register offsets
`define CFFB_A_CTRL  8'h00
`define CFFB_A_FILT  8'h04
`define CFFB_A_MASK  8'h08
`define CFFB_A_CMD   8'h0c
`define CFFB_A_STAT  8'h10
`define CFFB_A_MCNT  8'h14
`define CFFB_A_TSEL  8'h18
`define CFFB_A_TID   8'h1c
`define CFFB_A_TLO   8'h20
`define CFFB_A_THI   8'h24

// ==========================================
// Control fields and reset values
`define CFFB_B_EN      0
`define CFFB_B_EXT     1
`define CFFB_B_AUTO    2
`define CFFB_F_RATE    5:3
`define CFFB_B_MON     6
`define CFFB_B_SCAN    0
`define CFFB_CTRL_RST  7'h06
`define CFFB_FILT_RST  32'h0000_0000
`define CFFB_MASK_RST  8'hff
`define CFFB_STD_MAX   11'h7ff
`define CFFB_EXT_MAX   29'h1fff_ffff
`define CFFB_WILD      8'hff

// ==========================================
// Timing
`define CFFB_CLK_KHZ   100000
`define CFFB_MON_MS    3000
`define CFFB_SCAN_MS   100
`define CFFB_AUTO_MS   100
`define CFFB_TAB_N     8

`endif

// ### hw/cffb_pkg.sv
// Types shared by the CAN frame filter and byte select block.
// Assumes the frame source delivers whole decoded frames.
package cffb_pkg;

   // Bit rate codes handed to the bit engine
   typedef enum logic [2:0] {
      CFFB_R50  = 3'h0,
      CFFB_R100 = 3'h1,
      CFFB_R125 = 3'h2,
      CFFB_R250 = 3'h3,
      CFFB_R500 = 3'h4
   } cffb_rate_type;

   // Scan window states, Gray along idle-run-done
   typedef enum logic [1:0] {
      CFFB_SC_IDLE = 2'b00,
      CFFB_SC_RUN  = 2'b01,
      CFFB_SC_DONE = 2'b11
   } cffb_scan_type;

   // Received frame; data byte 1 sits in bits 7:0
   typedef struct packed {
      logic        ext;
      logic [28:0] id;
      logic [63:0] data;
   } cffb_frame_type;

   // Upstream record of selected bytes
   typedef struct packed {
      logic [3:0]  nbytes;
      logic [63:0] value;
   } cffb_rec_type;

endpackage

// ### hw/cffb_top.sv
// CAN frame filter, byte select, rate hunt and bus scan.
// Assumes decoded frames arrive synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "cffb_map.svh"

// ==========================================
// Record FIFO
module cffb_fifo #(
   parameter int unsigned WIDTH = 68,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;
   logic             full;
   logic             empty;

   // Pointers carry a wrap bit to tell full from empty
   assign empty     = (wp_q == rp_q);
   assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rp_q[AW-1:0]];

   // Write side
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wp_q <= '0;
      end else if (in_valid && !full) begin
         mem[wp_q[AW-1:0]] <= in_data;
         wp_q              <= wp_q + 1'b1;
      end
   end

   // Read side
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rp_q <= '0;
      end else if (out_ready && !empty) begin
         rp_q <= rp_q + 1'b1;
      end
   end
endmodule

// ==========================================
// Top level
module cffb_top #(
   parameter int unsigned MON_CYCLES  = `CFFB_MON_MS * `CFFB_CLK_KHZ,
   parameter int unsigned SCAN_CYCLES = `CFFB_SCAN_MS * `CFFB_CLK_KHZ,
   parameter int unsigned AUTO_CYCLES = `CFFB_AUTO_MS * `CFFB_CLK_KHZ,
   parameter int unsigned FIFO_DEPTH  = 16
) (
   input  wire logic                   ref_clk,
   input  wire logic                   rst_b,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [31:0]            reg_rdata,
   input  wire logic                   usb_attached,
   input  wire logic                   deep_sleep,
   output logic                        can_run,
   output logic      [2:0]             can_rate,
   input  wire logic                   rx_valid,
   output logic                        rx_ready,
   input  wire cffb_pkg::cffb_frame_type rx_frame,
   output logic                        rec_valid,
   input  wire logic                   rec_ready,
   output cffb_pkg::cffb_rec_type      rec_data
);
   import cffb_pkg::*;

   localparam logic [31:0] MON_LAST  = 32'(MON_CYCLES - 1);
   localparam logic [31:0] SCAN_LAST = 32'(SCAN_CYCLES - 1);
   localparam logic [31:0] AUTO_LAST = 32'(AUTO_CYCLES - 1);
   localparam int unsigned TN        = `CFFB_TAB_N;

   // ==========================================
   // Declarations
   logic [6:0]     ctrl_q;
   logic [31:0]    filt_q;
   logic [7:0]     mask_q;
   logic [2:0]     tsel_q;
   logic [31:0]    mcnt_q;
   logic [31:0]    rdata_q;
   logic [31:0]    mon_cnt_q;
   logic [31:0]    scan_cnt_q;
   logic [31:0]    auto_cnt_q;
   cffb_rate_type  rate_q;
   logic           lock_q;
   cffb_scan_type  scan_q;
   logic [3:0]     tab_cnt_q;
   logic [TN-1:0]  tab_v_q;
   logic           tab_ext_q [TN];
   logic [28:0]    tab_id_q  [TN];
   logic [63:0]    tab_dat_q [TN];
   logic [TN-1:0]  hit;
   logic           any_hit;
   logic           run;
   logic           take;
   logic           id_ok;
   logic           ext_ok;
   logic           std_ok;
   logic           scan_go;
   logic           mon_tick;
   logic           push;
   cffb_rec_type   sel_rec;
   cffb_rate_type  fixed_rate;

   // ==========================================
   // Byte selection and packing
   function automatic cffb_rec_type pack_sel(input logic [63:0] d,
                                             input logic [7:0]  m);
      cffb_rec_type r;
      logic [3:0]   n;
      r = '0;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         if (m[i]) begin
            r.value[n[2:0]*8 +: 8] = d[i*8 +: 8];
            n = n + 4'h1;
         end
      end
      r.nbytes = n;
      return r;
   endfunction

   // Block is live only when enabled, unplugged and awake
   assign run     = ctrl_q[`CFFB_B_EN] && !usb_attached && !deep_sleep;
   assign can_run = run;
   assign take    = run && rx_valid && rx_ready;

   // ==========================================
   // Acceptance filter
   // Outer bytes written as ff are don't-care
   always_comb begin
      ext_ok = rx_frame.ext;
      if (filt_q[31:24] != `CFFB_WILD) begin
         ext_ok = ext_ok && (filt_q[31:24] == {3'h0, rx_frame.id[28:24]});
      end
      if (filt_q[7:0] != `CFFB_WILD) begin
         ext_ok = ext_ok && (filt_q[7:0] == rx_frame.id[7:0]);
      end
      ext_ok = ext_ok && (filt_q[23:8] == rx_frame.id[23:8]);
   end

   // Standard frames compare the low 11 bits
   assign std_ok = !rx_frame.ext && (rx_frame.id[10:0] == (filt_q[10:0] & `CFFB_STD_MAX));

   // Identifier type selects the comparison
   assign id_ok = ctrl_q[`CFFB_B_EXT] ? ext_ok : std_ok;

   // Unmatched frames or an empty mask produce nothing
   assign push    = take && id_ok && (mask_q != 8'h00);
   assign sel_rec = pack_sel(rx_frame.data, mask_q);

   // ==========================================
   // Upstream record buffer
   cffb_fifo #(
      .WIDTH ($bits(cffb_rec_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .in_valid  (push),
      .in_ready  (rx_ready),
      .in_data   (sel_rec),
      .out_valid (rec_valid),
      .out_ready (rec_ready),
      .out_data  (rec_data)
   );

   // ==========================================
   // Bit rate selection
   // Out-of-range codes fall back to the top rate
   assign fixed_rate = (ctrl_q[`CFFB_F_RATE] > 3'(CFFB_R500)) ?
                       CFFB_R500 : cffb_rate_type'(ctrl_q[`CFFB_F_RATE]);
   assign can_rate   = rate_q;

   // Hunt through the rates until frames arrive
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rate_q     <= CFFB_R50;
         auto_cnt_q <= 32'h0;
         lock_q     <= 1'b0;
      end else if (!ctrl_q[`CFFB_B_AUTO]) begin
         rate_q     <= fixed_rate;
         auto_cnt_q <= 32'h0;
         lock_q     <= 1'b0;
      end else if (run && rx_valid) begin
         auto_cnt_q <= 32'h0;
         lock_q     <= 1'b1;
      end else if (run) begin
         if (auto_cnt_q == AUTO_LAST) begin
            auto_cnt_q <= 32'h0;
            lock_q     <= 1'b0;
            rate_q     <= (rate_q == CFFB_R500) ? CFFB_R50 :
                          cffb_rate_type'(rate_q + 3'h1);
         end else begin
            auto_cnt_q <= auto_cnt_q + 32'h1;
         end
      end
   end

   // ==========================================
   // Monitoring repeat timer
   assign mon_tick = run && ctrl_q[`CFFB_B_MON] && (mon_cnt_q == MON_LAST);

   // Counts 3 s periods while monitoring is on
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         mon_cnt_q <= 32'h0;
      end else if (!run || !ctrl_q[`CFFB_B_MON] || mon_tick) begin
         mon_cnt_q <= 32'h0;
      end else begin
         mon_cnt_q <= mon_cnt_q + 32'h1;
      end
   end

   // A command write or a monitor tick opens a scan
   assign scan_go = run && ((reg_wr && reg_addr == `CFFB_A_CMD && reg_wdata[`CFFB_B_SCAN])
                    || mon_tick);

   // ==========================================
   // Scan window state machine
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         scan_q     <= CFFB_SC_IDLE;
         scan_cnt_q <= 32'h0;
      end else begin
         case (scan_q)
            CFFB_SC_IDLE,
            CFFB_SC_DONE: begin
               scan_cnt_q <= 32'h0;
               if (scan_go) begin
                  scan_q <= CFFB_SC_RUN;
               end
            end
            CFFB_SC_RUN: begin
               if (!run || scan_cnt_q == SCAN_LAST) begin
                  scan_q <= CFFB_SC_DONE;
               end else begin
                  scan_cnt_q <= scan_cnt_q + 32'h1;
               end
            end
            default: begin
               scan_q <= CFFB_SC_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // Scan table entries
   assign any_hit = |hit;

   // Fill count; cleared when a scan opens
   always_ff @(posedge ref_clk) begin
      if (!rst_b || (scan_q != CFFB_SC_RUN && scan_go)) begin
         tab_cnt_q <= 4'h0;
      end else if (scan_q == CFFB_SC_RUN && take && !any_hit && tab_cnt_q < 4'(TN)) begin
         tab_cnt_q <= tab_cnt_q + 4'h1;
      end
   end

   // Each entry keeps one distinct identifier and its latest data
   for (genvar k = 0; k < TN; k++) begin : g_tab
      assign hit[k] = tab_v_q[k] && tab_ext_q[k] == rx_frame.ext && tab_id_q[k] == rx_frame.id;

      always_ff @(posedge ref_clk) begin
         if (!rst_b) begin
            tab_v_q[k]   <= 1'b0;
            tab_ext_q[k] <= 1'b0;
            tab_id_q[k]  <= 29'h0;
            tab_dat_q[k] <= 64'h0;
         end else if (scan_q != CFFB_SC_RUN && scan_go) begin
            tab_v_q[k] <= 1'b0;
         end else if (scan_q == CFFB_SC_RUN && take) begin
            if (hit[k]) begin
               tab_dat_q[k] <= rx_frame.data;
            end else if (!any_hit && tab_cnt_q == 4'(k)) begin
               tab_v_q[k]   <= 1'b1;
               tab_ext_q[k] <= rx_frame.ext;
               tab_id_q[k]  <= rx_frame.id;
               tab_dat_q[k] <= rx_frame.data;
            end
         end
      end
   end

   // ==========================================
   // Register writes
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ctrl_q <= `CFFB_CTRL_RST;
         filt_q <= `CFFB_FILT_RST;
         mask_q <= `CFFB_MASK_RST;
         tsel_q <= 3'h0;
      end else if (reg_wr) begin
         if (reg_addr == `CFFB_A_CTRL) begin
            ctrl_q <= reg_wdata[6:0];
         end else if (reg_addr == `CFFB_A_FILT) begin
            filt_q <= reg_wdata;
         end else if (reg_addr == `CFFB_A_MASK) begin
            mask_q <= reg_wdata[7:0];
         end else if (reg_addr == `CFFB_A_TSEL) begin
            tsel_q <= reg_wdata[2:0];
         end
      end
   end

   // Match counter; write any value to clear, a hit in the same cycle leaves it at 1
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         mcnt_q <= 32'h0;
      end else if (push) begin
         mcnt_q <= (reg_wr && reg_addr == `CFFB_A_MCNT) ? 32'h1 : mcnt_q + 32'h1;
      end else if (reg_wr && reg_addr == `CFFB_A_MCNT) begin
         mcnt_q <= 32'h0;
      end
   end

   // ==========================================
   // Register reads, data one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rdata_q <= 32'h0;
      end else if (reg_rd) begin
         if (reg_addr == `CFFB_A_CTRL) begin
            rdata_q <= {25'h0, ctrl_q};
         end else if (reg_addr == `CFFB_A_FILT) begin
            rdata_q <= filt_q;
         end else if (reg_addr == `CFFB_A_MASK) begin
            rdata_q <= {24'h0, mask_q};
         end else if (reg_addr == `CFFB_A_STAT) begin
            rdata_q <= {19'h0, tab_cnt_q, rx_ready, lock_q, run,
                        1'b0, rate_q, scan_q};
         end else if (reg_addr == `CFFB_A_MCNT) begin
            rdata_q <= mcnt_q;
         end else if (reg_addr == `CFFB_A_TSEL) begin
            rdata_q <= {29'h0, tsel_q};
         end else if (reg_addr == `CFFB_A_TID) begin
            rdata_q <= {tab_v_q[tsel_q], tab_ext_q[tsel_q], 1'b0, tab_id_q[tsel_q]};
         end else if (reg_addr == `CFFB_A_TLO) begin
            rdata_q <= tab_dat_q[tsel_q][31:0];
         end else if (reg_addr == `CFFB_A_THI) begin
            rdata_q <= tab_dat_q[tsel_q][63:32];
         end else begin
            rdata_q <= 32'h0;
         end
      end else begin
         rdata_q <= 32'h0;
      end
   end

   assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// ### dv/cffb_ecu_model.sv
// ECU side model: offers one decoded frame at a time.
// Assumes the bench pulses send with a frame on frame_in.
`timescale 1ns/1ps
`default_nettype none
module cffb_ecu_model (
   input  wire logic                     ref_clk,
   input  wire logic                     rst_b,
   input  wire logic                     send,
   input  wire cffb_pkg::cffb_frame_type frame_in,
   input  wire logic                     rx_ready,
   input  wire logic                     can_run,
   output logic                          rx_valid,
   output cffb_pkg::cffb_frame_type      rx_frame
);
   import cffb_pkg::*;
   // =====
   // Frame stays until taken; an idle line shows changing junk
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rx_valid <= 1'b0;
         rx_frame <= '0;
      end else if (send) begin
         rx_valid <= 1'b1;
         rx_frame <= frame_in;
      end else if (!rx_valid || (rx_ready && can_run)) begin
         rx_valid <= 1'b0;
         rx_frame <= ~rx_frame;
      end
   end
endmodule
`default_nettype wire

// ### dv/cffb_top_asserts.sv
// Checker for the frame filter ports.
// Assumes a bind onto cffb_top.
`timescale 1ns/1ps
`default_nettype none
module cffb_top_asserts (
   input wire logic                   ref_clk,
   input wire logic                   rst_b,
   input wire logic                   reg_wr,
   input wire logic                   usb_attached,
   input wire logic                   deep_sleep,
   input wire logic                   can_run,
   input wire logic [2:0]             can_rate,
   input wire logic                   rx_valid,
   input wire logic                   rx_ready,
   input wire logic                   rec_valid,
   input wire logic                   rec_ready,
   input wire cffb_pkg::cffb_rec_type rec_data
);
   import cffb_pkg::*;
   logic [1:0] age_q;
   logic       took_q;
   // =====
   // Cycles since a register write, and a frame taken last cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         age_q <= 2'h0;
         took_q <= 1'b0;
      end else begin
         age_q <= reg_wr ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
         took_q <= rx_valid && rx_ready && can_run;
      end
   end
   // =====
   // Properties
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence s_stall; rec_valid && !rec_ready; endsequence
   sequence s_kept; rec_valid && $stable(rec_data); endsequence
   property p_gate; can_run |-> !usb_attached && !deep_sleep; endproperty
   property p_rate; can_rate <= 3'h4; endproperty
   property p_step; $changed(can_rate) && age_q == 2'h3 |->
      can_rate == ($past(can_rate) == 3'h4 ? 3'h0 : $past(can_rate) + 3'h1); endproperty
   property p_take; $rose(rec_valid) |-> took_q; endproperty
   property p_cnt; rec_valid |-> rec_data.nbytes inside {[4'h1:4'h8]}; endproperty
   property p_pack; rec_valid |-> (rec_data.value >> {rec_data.nbytes, 3'h0}) == 64'h0;
   endproperty
   property p_hold; s_stall |=> s_kept; endproperty
   property p_full; !rx_ready |-> rec_valid; endproperty
   a_gate: assert property (p_gate) else $error("run while stopped");
   a_rate: assert property (p_rate) else $error("rate code out of range");
   a_step: assert property (p_step) else $error("rate hunt skipped a step");
   a_take: assert property (p_take) else $error("record without a frame");
   a_cnt: assert property (p_cnt) else $error("bad byte count");
   a_pack: assert property (p_pack) else $error("bytes above count");
   a_hold: assert property (p_hold) else $error("record lost while stalled");
   a_full: assert property (p_full) else $error("refused while empty");
endmodule
`default_nettype wire

// ### dv/cffb_top_test.sv
// Bench: table of filter cases, then rate, gating, buffer, scan and reset.
// Assumes design, ECU model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "cffb_map.svh"
module cffb_top_test;
   import cffb_pkg::*;
   typedef struct packed {
      logic           ext_mode;
      logic [31:0]    filt;
      logic [7:0]     mask;
      cffb_frame_type f;
      cffb_rec_type   r;
   } cffb_row_type;
   logic           ref_clk = 1'b0;
   logic           rst_b = 1'b0;
   logic [7:0]     reg_addr = 8'h00;
   logic [31:0]    reg_wdata = 32'h0;
   logic           reg_wr = 1'b0, reg_rd = 1'b0, usb_attached = 1'b0, deep_sleep = 1'b0;
   logic           rec_ready = 1'b0, send = 1'b0;
   logic [31:0]    reg_rdata, w;
   logic [2:0]     can_rate;
   logic           can_run, rx_valid, rx_ready, rec_valid;
   cffb_frame_type rx_frame, frame_in = '0;
   cffb_rec_type   rec_data;
   int             fails = 0, samples_checked = 0, i;
   logic [2:0]     rc [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   logic [7:0]     ra [4] = '{`CFFB_A_CTRL, `CFFB_A_FILT, `CFFB_A_MASK, 8'hfc};
   logic [31:0]    rv [4] = '{32'h6, 32'h0, 32'hff, 32'h0};
   // Filter cases; a zero count means nothing may come out
   cffb_row_type   rows [9] = '{
      '{1'b1, 32'hfffee9ff, 8'hf0, '{1'b1, 29'h18fee900, 64'h00038423ffffffff}, '{4'h4, 64'h38423}},
      '{1'b1, 32'hfffee9ff, 8'h0f, '{1'b1, 29'h0cfee9aa, 64'h0102030405060708}, '{4'h4, 64'h5060708}},
      '{1'b1, 32'hfffee9ff, 8'hff, '{1'b1, 29'h18fee800, 64'h1}, '{4'h0, 64'h0}},
      '{1'b1, 32'hfffee9ff, 8'hff, '{1'b0, 29'h18fee900, 64'h1}, '{4'h0, 64'h0}},
      '{1'b0, 32'h000007ff, 8'h01, '{1'b0, 29'h7ff, 64'h99ab}, '{4'h1, 64'hab}},
      '{1'b0, 32'h00000123, 8'h00, '{1'b0, 29'h123, 64'h1}, '{4'h0, 64'h0}},
      '{1'b0, 32'h00000123, 8'h81, '{1'b0, 29'h123, 64'h1122334455667788}, '{4'h2, 64'h1188}},
      '{1'b1, 32'h1fffffff, 8'hff, '{1'b1, 29'h1fffffff, 64'h1}, '{4'h8, 64'h1}},
      '{1'b0, 32'h00000123, 8'h81, '{1'b1, 29'h123, 64'h1}, '{4'h0, 64'h0}}};

   // =====
   // Design, far side and checker hookup
   cffb_top #(.MON_CYCLES(200), .SCAN_CYCLES(20), .AUTO_CYCLES(16), .FIFO_DEPTH(16)) uut (
      .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_attached(usb_attached),
      .deep_sleep(deep_sleep), .can_run(can_run), .can_rate(can_rate), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_frame(rx_frame), .rec_valid(rec_valid),
      .rec_ready(rec_ready), .rec_data(rec_data));
   cffb_ecu_model ecu (.ref_clk(ref_clk), .rst_b(rst_b), .send(send), .frame_in(frame_in),
      .rx_ready(rx_ready), .can_run(can_run), .rx_valid(rx_valid), .rx_frame(rx_frame));
   // Clock
   always #5 ref_clk = ~ref_clk;

   // =====
   // Reporting
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t word %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_rec(input cffb_rec_type got, input cffb_rec_type exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t record %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_up(input string what);
      fails++;
      $display("MISMATCH %0t no %s", $time, what);
      close_out;
   endtask

   // =====
   // Register port and frame tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic snd(input cffb_frame_type f);
      @(posedge ref_clk);
      frame_in <= f;
      send <= 1'b1;
      @(posedge ref_clk);
      send <= 1'b0;
   endtask
   task automatic taken;
      #1;
      for (i = 0; i < 40 && rx_valid !== 1'b0; i++) @(posedge ref_clk) #1;
      if (i == 40) give_up("take");
   endtask
   task automatic pop(input cffb_rec_type exp);
      #1;
      for (i = 0; i < 40 && rec_valid !== 1'b1; i++) @(posedge ref_clk) #1;
      if (i == 40) give_up("record");
      chk_rec(rec_data, exp);
      @(posedge ref_clk);
      rec_ready <= 1'b1;
      @(posedge ref_clk);
      rec_ready <= 1'b0;
   endtask
   task automatic quiet;
      repeat (4) @(posedge ref_clk);
      #1 chk_word({31'h0, rec_valid}, 32'h0);
   endtask

   // =====
   // Main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      foreach (rows[k]) begin
         wr(`CFFB_A_CTRL, {26'h0, 3'h3, 1'b0, rows[k].ext_mode, 1'b1});
         wr(`CFFB_A_FILT, rows[k].filt);
         wr(`CFFB_A_MASK, {24'h0, rows[k].mask});
         snd(rows[k].f);
         taken;
         if (rows[k].r.nbytes != 4'h0) pop(rows[k].r);
         else quiet;
      end
      // Fixed rates; a code above the top rate falls back to it
      foreach (rc[r]) begin
         wr(`CFFB_A_CTRL, {26'h0, rc[r], 3'h3});
         repeat (3) @(posedge ref_clk);
         #1 chk_word({29'h0, can_rate}, rc[r] > 3'h4 ? 32'h4 : {29'h0, rc[r]});
      end
      // No frame is taken with USB attached or in deep sleep
      wr(`CFFB_A_FILT, 32'hfffee9ff);
      wr(`CFFB_A_MASK, 32'hff);
      usb_attached <= 1'b1;
      snd('{1'b1, 29'h18fee900, 64'h77});
      repeat (4) @(posedge ref_clk);
      #1 chk_word({30'h0, can_run, rx_valid}, 32'h1);
      usb_attached <= 1'b0;
      deep_sleep <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 chk_word({30'h0, can_run, rx_valid}, 32'h1);
      deep_sleep <= 1'b0;
      taken;
      pop('{4'h8, 64'h77});
      // Fill the record buffer until it refuses, then drain in order
      for (int j = 0; j < 17; j++) begin
         snd('{1'b1, 29'h18fee900, 64'(j)});
         if (j < 16) taken;
      end
      repeat (3) @(posedge ref_clk);
      #1 chk_word({30'h0, rx_ready, rx_valid}, 32'h1);
      for (int j = 0; j < 17; j++) pop('{4'h8, 64'(j)});
      quiet;
      // Automatic rate steps on with no traffic
      wr(`CFFB_A_CTRL, 32'h7);
      repeat (3) @(posedge ref_clk);
      #1 w = {29'h0, can_rate};
      for (i = 0; i < 40 && {29'h0, can_rate} === w; i++) @(posedge ref_clk) #1;
      chk_word({29'h0, can_rate}, w == 32'h4 ? 32'h0 : w + 32'h1);
      // One scan records the frame seen; monitoring starts it again
      wr(`CFFB_A_CMD, 32'h1);
      rd(`CFFB_A_STAT, w);
      chk_word({30'h0, w[1:0]}, 32'h1);
      snd('{1'b1, 29'h18fee900, 64'h5});
      taken;
      pop('{4'h8, 64'h5});
      repeat (30) @(posedge ref_clk);
      rd(`CFFB_A_STAT, w);
      chk_word({19'h0, w[12:9], 7'h0, w[1:0]}, 32'h203);
      wr(`CFFB_A_TSEL, 32'h0);
      rd(`CFFB_A_TID, w);
      chk_word(w, {3'b110, 29'h18fee900});
      rd(`CFFB_A_TLO, w);
      chk_word(w, 32'h5);
      @(posedge ref_clk);
      #1 chk_word(reg_rdata, 32'h0);
      rd(`CFFB_A_MCNT, w);
      chk_word(w, 32'h18);
      wr(`CFFB_A_CTRL, 32'h47);
      for (i = 0; i < 150 && w[1:0] !== 2'b01; i++) rd(`CFFB_A_STAT, w);
      chk_word({30'h0, w[1:0]}, 32'h1);
      // Reset returns registers to their defaults; unmapped reads give zero
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      #1 chk_word({29'h0, can_run, rec_valid, rx_ready}, 32'h1);
      foreach (ra[k]) begin
         rd(ra[k], w);
         chk_word(w, rv[k]);
      end
      close_out;
   end
endmodule

bind cffb_top cffb_top_asserts chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr),
   .usb_attached(usb_attached), .deep_sleep(deep_sleep), .can_run(can_run),
   .can_rate(can_rate), .rx_valid(rx_valid), .rx_ready(rx_ready), .rec_valid(rec_valid),
   .rec_ready(rec_ready), .rec_data(rec_data));
`default_nettype wire
